// ---- common/dfs_pkg.sv ----
// constants for the dark readout and flash strobe block
// assumes one pixel-rate clock and a plain strobe register port
package dfs_pkg;
    localparam logic [7:0] SHIELD_CTRL_ADDR = 8'h22;
    localparam logic [7:0] STROBE_CTRL_ADDR = 8'h23;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h30;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h31;
    // shield readout control fields
    localparam int SH_WIDE_BIT = 10;
    localparam int SH_SHOW_COL_BIT = 9;
    localparam int SH_READ_COL_BIT = 8;
    localparam int SH_SHOW_ROW_BIT = 7;
    localparam int SH_START_LSB = 4;
    localparam int SH_ROW_EN_BIT = 3;
    localparam int SH_NUM_LSB = 0;
    // strobe control fields
    localparam int ST_PIN_BIT = 15;
    localparam int ST_TRIG_BIT = 14;
    localparam int ST_XENON_BIT = 13;
    localparam int ST_DELAY_LSB = 11;
    localparam int ST_AFTER_RESET_BIT = 10;
    localparam int ST_EVERY_BIT = 9;
    localparam int ST_HELD_BIT = 8;
    localparam int ST_COUNT_LSB = 0;
    // reset values and writable bits
    localparam logic [15:0] SHIELD_CTRL_RST = 16'h010F;
    localparam logic [15:0] SHIELD_WR_MASK = 16'h07FF;
    localparam logic [15:0] STROBE_CTRL_RST = 16'h0608;
    localparam logic [15:0] STROBE_WR_MASK = 16'h3FFF;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;
    // interrupt status bits
    localparam int IRQ_RISE_BIT = 0;
    localparam int IRQ_FALL_BIT = 1;
    localparam int IRQ_FRAME_BIT = 2;
    // counts
    localparam logic [5:0] COLS_NARROW = 6'h14;
    localparam logic [5:0] COLS_WIDE = 6'h24;
    localparam logic [5:0] COLS_BINNED = 6'h28;
    localparam logic [5:0] COL_GAP = 6'h02;
    localparam logic [3:0] ROW_GUARD = 4'h4;
    localparam logic [17:0] XENON_STEP_CYCLES = 18'h00400;
    localparam logic [7:0] XENON_COUNT_MAX = 8'hFF;
    typedef enum logic [1:0] {STB_IDLE, STB_XENON, STB_HELD} dfs_stb_t;
endpackage : dfs_pkg

// ---- hw/dfs_top.sv ----
// dark column/row readout sequencing and flash strobe control
// assumes frame and row events come from core logic on the same clock
`timescale 1ns/10ps
module dfs_top #(
    parameter logic [11:0] ACTIVE_COLS = 12'h640,
    parameter logic [11:0] HBLANK = 12'h1C2,
    parameter logic [11:0] ACTIVE_ROWS = 12'h4B0,
    parameter logic [11:0] BASE_MIN_HBLANK = 12'h050
) (
    input wire logic REF_CLK_IN,
    input wire logic RSTN_IN,
    input wire logic CE_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [15:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [15:0] REG_RDATA_OUT,
    input wire logic BINNING_IN,
    input wire logic FRAME_START_IN,
    input wire logic RESET_END_IN,
    input wire logic ROW_START_IN,
    input wire logic READOUT_END_IN,
    input wire logic VBLANK_IN,
    output logic LINE_VALID_OUT,
    output logic FRAME_VALID_OUT,
    output logic SHIELD_COL_OUT,
    output logic NOISE_COL_OUT,
    output logic DARK_ROW_OUT,
    output logic [3:0] DARK_ROW_ADDR_OUT,
    output logic [11:0] MIN_HBLANK_OUT,
    output logic ONE_FRAME_INTEG_OUT,
    output logic STROBE_OUT,
    output logic IRQ_OUT
);
    import dfs_pkg::*;

    function automatic logic [5:0] shield_cols(input logic binned, input logic wide);
        shield_cols = binned ? COLS_BINNED : (wide ? COLS_WIDE : COLS_NARROW);
    endfunction : shield_cols

    logic [15:0] shield_q;
    logic [13:0] cfg_q;
    logic [2:0] stat_q;
    logic [2:0] mask_q;
    logic irq_q;
    logic [15:0] rdata_q;
    logic [11:0] col_q;
    logic [11:0] row_q;
    logic row_dark_q;
    logic row_act_q;
    logic lv_q;
    logic fv_q;
    logic shield_col_q;
    logic noise_q;
    logic [3:0] row_addr_q;
    logic [11:0] min_hb_q;
    logic integ_q;
    dfs_stb_t st_q;
    dfs_stb_t st_d;
    logic [1:0] delay_q;
    logic done_q;
    logic [17:0] pulse_q;
    logic strobe_q;
    logic trig_q;

    // register decode
    wire wr_shield = CE_IN & REG_WR_IN & (REG_ADDR_IN == SHIELD_CTRL_ADDR);
    wire wr_strobe = CE_IN & REG_WR_IN & (REG_ADDR_IN == STROBE_CTRL_ADDR);
    wire wr_mask = CE_IN & REG_WR_IN & (REG_ADDR_IN == IRQ_MASK_ADDR);
    wire rd_stat = CE_IN & REG_RD_IN & (REG_ADDR_IN == IRQ_STAT_ADDR);
    wire [15:0] shield_rd = shield_q & SHIELD_WR_MASK;
    wire [15:0] strobe_rd = {strobe_q, trig_q, cfg_q};
    wire [15:0] rdata_d = !(CE_IN & REG_RD_IN) ? 16'h0000 :
        (REG_ADDR_IN == SHIELD_CTRL_ADDR) ? shield_rd :
        (REG_ADDR_IN == STROBE_CTRL_ADDR) ? strobe_rd :
        (REG_ADDR_IN == IRQ_STAT_ADDR) ? {13'h0000, stat_q} :
        (REG_ADDR_IN == IRQ_MASK_ADDR) ? {13'h0000, mask_q} : 16'h0000;

    // configuration fields
    wire sh_wide = shield_q[SH_WIDE_BIT];
    wire show_col = shield_q[SH_SHOW_COL_BIT];
    wire read_col = shield_q[SH_READ_COL_BIT];
    wire show_row = shield_q[SH_SHOW_ROW_BIT];
    wire [2:0] row_start = shield_q[SH_START_LSB +: 3];
    wire row_en = shield_q[SH_ROW_EN_BIT];
    wire [2:0] row_num = shield_q[SH_NUM_LSB +: 3];
    wire xen_en = cfg_q[ST_XENON_BIT];
    wire [1:0] cfg_delay = cfg_q[ST_DELAY_LSB +: 2];
    wire after_reset = cfg_q[ST_AFTER_RESET_BIT];
    wire every = cfg_q[ST_EVERY_BIT];
    wire held_en = cfg_q[ST_HELD_BIT];
    wire [7:0] xen_count = cfg_q[ST_COUNT_LSB +: 8];

    // column windows within a row
    wire [5:0] cols_w = shield_cols(BINNING_IN, sh_wide);
    wire [11:0] lead_w = 12'(cols_w + COL_GAP);
    wire [11:0] act_start = HBLANK;
    wire [11:0] act_end = 12'(HBLANK + ACTIVE_COLS);
    wire [11:0] lv_start = show_col ? 12'(HBLANK - lead_w) : act_start;
    wire [11:0] shield_end = 12'(HBLANK - 12'(COL_GAP));
    wire [11:0] noise_start = 12'(HBLANK - 12'(cols_w));
    wire row_vis = row_act_q | (row_dark_q & show_row);
    wire row_any = row_act_q | row_dark_q;
    wire lv_d = row_vis & (col_q >= lv_start) & (col_q < act_end);
    wire shield_d = row_vis & show_col & (col_q >= lv_start) & (col_q < shield_end);
    wire noise_d = row_any & read_col & (col_q >= noise_start) & (col_q < act_start);
    wire [11:0] min_hb_d = read_col ? 12'(BASE_MIN_HBLANK + 12'(cols_w)) : BASE_MIN_HBLANK;

    // row classification
    wire [11:0] dark_n = row_en ? 12'({1'b0, row_num} + 4'h1) : 12'h000;
    wire row_dark_d = row_q < dark_n;
    wire row_act_d = !row_dark_d & (row_q < 12'(dark_n + ACTIVE_ROWS));
    wire [3:0] row_addr_d = 4'({1'b0, row_start} + ROW_GUARD + row_q[3:0]);

    // strobe sequencing
    wire fire_ok = (delay_q == 2'h0) & !done_q;
    wire xen_trig = after_reset ? RESET_END_IN : READOUT_END_IN;
    wire [17:0] pulse_len = 18'(xen_count) * XENON_STEP_CYCLES;
    wire xen_cut = (xen_count == XENON_COUNT_MAX) & ROW_START_IN;
    wire xen_end = (pulse_q == 18'h00001) | xen_cut | !VBLANK_IN;
    wire xen_go = xen_en & fire_ok & xen_trig & VBLANK_IN & (xen_count != 8'h00);
    wire held_go = held_en & fire_ok & FRAME_START_IN;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            STB_IDLE: begin
                if (held_go) begin
                    st_d = STB_HELD;
                end else if (xen_go) begin
                    st_d = STB_XENON;
                end
            end
            STB_XENON: begin
                if (xen_end) begin
                    st_d = STB_IDLE;
                end
            end
            STB_HELD: begin
                if (READOUT_END_IN) begin
                    st_d = STB_IDLE;
                end
            end
        endcase
        if ((st_q == STB_XENON && !xen_en) || (st_q == STB_HELD && !held_en)) begin
            st_d = STB_IDLE;
        end
    end

    wire strobe_d = (st_d != STB_IDLE);
    wire strobe_rise = strobe_d & !strobe_q;
    wire strobe_fall = !strobe_d & strobe_q;
    wire [2:0] ev = {FRAME_START_IN, strobe_fall, strobe_rise};
    wire [2:0] stat_d = (rd_stat ? 3'h0 : stat_q) | ev;

    // register file
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            shield_q <= SHIELD_CTRL_RST;
            cfg_q <= STROBE_CTRL_RST[13:0];
            mask_q <= IRQ_MASK_RST;
            stat_q <= 3'h0;
            irq_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else if (CE_IN) begin
            if (wr_shield) begin
                shield_q <= REG_WDATA_IN & SHIELD_WR_MASK;
            end
            if (wr_strobe) begin
                cfg_q <= REG_WDATA_IN[13:0];
            end
            if (wr_mask) begin
                mask_q <= REG_WDATA_IN[2:0];
            end
            stat_q <= stat_d;
            irq_q <= |(stat_d & mask_q);
            rdata_q <= rdata_d;
        end
    end

    // line and frame qualifiers
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            col_q <= 12'h000;
            row_q <= 12'h000;
            row_dark_q <= 1'b0;
            row_act_q <= 1'b0;
            row_addr_q <= 4'h0;
        end else if (CE_IN) begin
            if (ROW_START_IN) begin
                col_q <= 12'h000;
            end else if (col_q != 12'hFFF) begin
                col_q <= 12'(col_q + 12'h001);
            end
            if (FRAME_START_IN) begin
                row_q <= 12'h000;
            end else if (ROW_START_IN && row_q != 12'hFFF) begin
                row_q <= 12'(row_q + 12'h001);
            end
            if (READOUT_END_IN || FRAME_START_IN) begin
                row_dark_q <= 1'b0;
                row_act_q <= 1'b0;
            end else if (ROW_START_IN) begin
                row_dark_q <= row_dark_d;
                row_act_q <= row_act_d;
                row_addr_q <= row_addr_d;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            lv_q <= 1'b0;
            fv_q <= 1'b0;
            shield_col_q <= 1'b0;
            noise_q <= 1'b0;
            min_hb_q <= 12'h000;
            integ_q <= 1'b0;
        end else if (CE_IN) begin
            lv_q <= lv_d;
            fv_q <= row_vis;
            shield_col_q <= shield_d;
            noise_q <= noise_d;
            min_hb_q <= min_hb_d;
            integ_q <= xen_en;
        end
    end

    // strobe state
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            st_q <= STB_IDLE;
            strobe_q <= 1'b0;
            trig_q <= 1'b0;
            pulse_q <= 18'h00000;
            delay_q <= STROBE_CTRL_RST[ST_DELAY_LSB +: 2];
            done_q <= 1'b0;
        end else if (CE_IN) begin
            st_q <= st_d;
            strobe_q <= strobe_d;
            trig_q <= strobe_rise | (trig_q & !FRAME_START_IN);
            if (st_q == STB_IDLE && st_d == STB_XENON) begin
                pulse_q <= pulse_len;
            end else if (pulse_q != 18'h00000) begin
                pulse_q <= 18'(pulse_q - 18'h00001);
            end
            if (wr_strobe) begin
                delay_q <= REG_WDATA_IN[ST_DELAY_LSB +: 2];
            end else if (FRAME_START_IN && delay_q != 2'h0 && st_q == STB_IDLE) begin
                delay_q <= 2'(delay_q - 2'h1);
            end
            // a pulse ending beside a rewrite still spends the single shot
            if (strobe_fall && !every) begin
                done_q <= 1'b1;
            end else if (wr_strobe) begin
                done_q <= 1'b0;
            end
        end
    end

    assign REG_RDATA_OUT = rdata_q;
    assign LINE_VALID_OUT = lv_q;
    assign FRAME_VALID_OUT = fv_q;
    assign SHIELD_COL_OUT = shield_col_q;
    assign NOISE_COL_OUT = noise_q;
    assign DARK_ROW_OUT = row_dark_q;
    assign DARK_ROW_ADDR_OUT = row_addr_q;
    assign MIN_HBLANK_OUT = min_hb_q;
    assign ONE_FRAME_INTEG_OUT = integ_q;
    assign STROBE_OUT = strobe_q;
    assign IRQ_OUT = irq_q;

    // checks
    default clocking dfs_cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RSTN_IN);

    logic [17:0] xen_len_q;
    always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            xen_len_q <= 18'h00000;
        end else if (CE_IN) begin
            xen_len_q <= (st_q == STB_XENON) ? 18'(xen_len_q + 18'h00001) : 18'h00000;
        end
    end

    a_strobe_off_idle: assert property (CE_IN && !xen_en && !held_en |=> !STROBE_OUT)
        else $error("strobe high with no mode enabled");
    a_pin_readback: assert property (CE_IN && REG_RD_IN && REG_ADDR_IN == STROBE_CTRL_ADDR
        |=> REG_RDATA_OUT[ST_PIN_BIT] == $past(strobe_q))
        else $error("pin level bit wrong");
    a_trig_flag_set: assert property ($rose(strobe_q) |-> trig_q)
        else $error("triggered flag missing");
    a_trig_new_frame: assert property (CE_IN && FRAME_START_IN && st_d == STB_IDLE |=> !trig_q)
        else $error("triggered flag kept into new frame");
    a_xen_in_blank: assert property (CE_IN && $past(CE_IN) && st_q == STB_XENON |-> $past(VBLANK_IN))
        else $error("xenon pulse outside vertical blank");
    a_xen_blank_end: assert property (CE_IN && st_q == STB_XENON && !VBLANK_IN |=> !STROBE_OUT)
        else $error("xenon pulse kept after vertical blank");
    a_xen_pulse_len: assert property (CE_IN && st_q == STB_XENON |-> xen_len_q < pulse_len)
        else $error("xenon pulse too long");
    a_xen_trig_point: assert property (CE_IN && st_q == STB_IDLE && !held_go
        && !(after_reset ? RESET_END_IN : READOUT_END_IN) |=> !STROBE_OUT)
        else $error("xenon fired off its trigger point");
    a_xen_fires: assert property (CE_IN && st_q == STB_IDLE && !held_go && xen_en && fire_ok
        && VBLANK_IN && xen_count != 8'h00 && (after_reset ? RESET_END_IN : READOUT_END_IN) |=> STROBE_OUT)
        else $error("xenon not fired at trigger point");
    a_held_start: assert property (CE_IN && st_q == STB_IDLE && held_go |=> STROBE_OUT)
        else $error("held strobe not raised at frame start");
    a_held_end: assert property (CE_IN && st_q == STB_HELD && READOUT_END_IN |=> !STROBE_OUT)
        else $error("held strobe not dropped at readout end");
    a_delay_holds: assert property (CE_IN && delay_q != 2'h0 && st_q == STB_IDLE |=> !STROBE_OUT)
        else $error("strobe fired during frame delay");
    a_single_shot: assert property (CE_IN && done_q && st_q == STB_IDLE |=> !STROBE_OUT)
        else $error("single shot strobe repeated");
    a_lead_narrow: assert property (CE_IN && row_vis && show_col && !BINNING_IN && !sh_wide
        && col_q == 12'(HBLANK - 12'h016) |=> LINE_VALID_OUT)
        else $error("line qualifier not 22 early");
    a_lead_exact: assert property (CE_IN && row_vis && show_col && !BINNING_IN && !sh_wide
        && col_q == 12'(HBLANK - 12'h017) |=> !LINE_VALID_OUT)
        else $error("line qualifier more than 22 early");
    a_noise_window: assert property (CE_IN && row_any && read_col
        && col_q == 12'(HBLANK - 12'h001) |=> NOISE_COL_OUT)
        else $error("noise column missing before active");
    a_show_row_fv: assert property (CE_IN && row_dark_q && show_row |=> FRAME_VALID_OUT)
        else $error("frame qualifier low on shown dark row");
    a_dark_row_count: assert property (CE_IN && ROW_START_IN && !FRAME_START_IN && !READOUT_END_IN
        && row_en && row_q == 12'(row_num) |=> DARK_ROW_OUT ##0 $past(row_q) == 12'(row_num))
        else $error("last dark row missing");
    a_dark_row_stop: assert property (CE_IN && ROW_START_IN && !FRAME_START_IN && !READOUT_END_IN
        && row_q == dark_n |=> !DARK_ROW_OUT)
        else $error("extra dark row read");
    a_row_guard: assert property (CE_IN && ROW_START_IN && !FRAME_START_IN && !READOUT_END_IN
        && row_en && row_q == 12'h000 |=> DARK_ROW_ADDR_OUT == 4'($past(row_start)) + ROW_GUARD)
        else $error("guard offset missing");
    a_min_hblank: assert property (CE_IN && read_col && BINNING_IN
        |=> MIN_HBLANK_OUT == 12'(BASE_MIN_HBLANK + 12'(COLS_BINNED)))
        else $error("minimum blanking not raised");

    c_xenon_pulse: cover property (st_q == STB_IDLE ##1 st_q == STB_XENON);
    c_held_pulse: cover property (st_q == STB_HELD && READOUT_END_IN);
    c_shield_line: cover property ($rose(SHIELD_COL_OUT));
    c_dark_row: cover property ($rose(DARK_ROW_OUT) && FRAME_VALID_OUT == 1'b0);
    c_vblank_cut: cover property (st_q == STB_XENON && !VBLANK_IN);
endmodule : dfs_top

// ---- dv/dfs_flash_drv.sv ----
// flash driver model: counts strobe pulses, times the last one
// assumes an active high strobe on the block clock
`timescale 1ns/10ps
module dfs_flash_drv (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic strobe_in,
    output logic [7:0] pulses_out,
    output logic [17:0] width_out
);
    logic [17:0] run_q;
    logic prev_q;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_q <= 18'h00000;
            prev_q <= 1'b0;
            pulses_out <= 8'h00;
            width_out <= 18'h00000;
        end else begin
            prev_q <= strobe_in;
            run_q <= strobe_in ? run_q + 18'h00001 : 18'h00000;
            if (strobe_in && !prev_q) pulses_out <= pulses_out + 8'h01;
            if (!strobe_in && prev_q) width_out <= run_q;
        end
    end
endmodule : dfs_flash_drv

// ---- dv/tb.sv ----
// self-checking bench: registers, dark readout, flash strobe
// assumes the flash driver model dfs_flash_drv
`timescale 1ns/10ps
module tb;
    import dfs_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic bin = 1'b0;
    logic vbl = 1'b0;
    logic ce = 1'b1;
    logic [3:0] ev = 4'h0;
    logic [15:0] rdata;
    logic lv, fv, shc, noc, drow, integ, stb, irq;
    logic [3:0] draddr;
    logic [11:0] minhb;
    logic [7:0] npulse;
    logic [17:0] width;
    logic dk_s, fv_s;
    logic [3:0] ad_s;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    int lv_n, lv_first, sh_n, sh_first, no_n, lv_base, c, lead, dk;
    logic [3:0] ccfg [5] = '{4'b0001, 4'b1001, 4'b1101, 4'b1111, 4'b0110};
    logic [6:0] rcfg [3] = '{7'b1010011, 7'b1000111, 7'b0001001};

    initial forever #2.5 clk = ~clk;

    dfs_top #(.ACTIVE_COLS(12'h028), .HBLANK(12'h03C), .ACTIVE_ROWS(12'h008), .BASE_MIN_HBLANK(12'h050)) dfs_top_inst (
        .REF_CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .BINNING_IN(bin),
        .FRAME_START_IN(ev[0]), .RESET_END_IN(ev[1]), .ROW_START_IN(ev[2]), .READOUT_END_IN(ev[3]),
        .VBLANK_IN(vbl), .LINE_VALID_OUT(lv), .FRAME_VALID_OUT(fv), .SHIELD_COL_OUT(shc),
        .NOISE_COL_OUT(noc), .DARK_ROW_OUT(drow), .DARK_ROW_ADDR_OUT(draddr), .MIN_HBLANK_OUT(minhb),
        .ONE_FRAME_INTEG_OUT(integ), .STROBE_OUT(stb), .IRQ_OUT(irq));

    dfs_flash_drv dfs_flash_drv_inst (.clk_in(clk), .rst_n_in(rstn), .strobe_in(stb),
        .pulses_out(npulse), .width_out(width));

    task automatic report_and_stop();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_reg

    // 0 frame start, 1 reset end, 2 row start, 3 readout end
    task automatic pulse(input int k);
        @(posedge clk);
        ev <= 4'h1 << k;
        @(posedge clk);
        ev <= 4'h0;
    endtask : pulse

    task automatic row_scan();
        lv_n = 0;
        sh_n = 0;
        no_n = 0;
        pulse(2);
        for (int i = 0; i < 104; i++) begin
            @(posedge clk);
            #1;
            if (lv === 1'b1 && lv_n == 0) lv_first = i;
            if (shc === 1'b1 && sh_n == 0) sh_first = i;
            lv_n += (lv === 1'b1);
            sh_n += (shc === 1'b1);
            no_n += (noc === 1'b1);
            if (i == 5) {dk_s, fv_s, ad_s} = {drow, fv, draddr};
        end
    endtask : row_scan

    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            $display("ERROR %0t: run did not finish", $time);
            report_and_stop();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        tick(1);
        chk(stb, 1'b0);
        chk(minhb, 12'h064);
        rd_reg(SHIELD_CTRL_ADDR, SHIELD_CTRL_RST);
        rd_reg(STROBE_CTRL_ADDR, STROBE_CTRL_RST);
        rd_reg(IRQ_MASK_ADDR, 16'h0000);
        rd_reg(8'h40, 16'h0000);
        wr_reg(SHIELD_CTRL_ADDR, 16'hFF8F);
        rd_reg(SHIELD_CTRL_ADDR, 16'h078F);
        foreach (ccfg[k]) begin
            c = ccfg[k][1] ? 40 : (ccfg[k][2] ? 36 : 20);
            lead = ccfg[k][3] ? c + 2 : 0;
            @(posedge clk);
            bin <= ccfg[k][1];
            wr_reg(SHIELD_CTRL_ADDR, {5'h00, ccfg[k][2], ccfg[k][3], ccfg[k][0], 8'h08});
            pulse(0);
            row_scan();
            row_scan();
            if (k == 0) lv_base = lv_first;
            chk(lv_n, 40 + lead);
            chk(lv_base - lv_first, lead);
            chk(sh_n, ccfg[k][3] ? c : 0);
            if (ccfg[k][3]) chk(sh_first + c + 2, lv_base);
            chk(no_n, ccfg[k][0] ? c : 0);
            chk(minhb, 80 + (ccfg[k][0] ? c : 0));
        end
        @(posedge clk);
        bin <= 1'b0;
        foreach (rcfg[k]) begin
            wr_reg(SHIELD_CTRL_ADDR, {8'h01, rcfg[k][6:3], 1'b1, rcfg[k][2:0]});
            pulse(0);
            dk = 0;
            repeat (10) begin
                row_scan();
                if (dk_s === 1'b1) begin
                    chk(ad_s, rcfg[k][5:3] + 4 + dk);
                    chk(fv_s, rcfg[k][6]);
                    dk++;
                end
            end
            chk(dk, rcfg[k][2:0] + 1);
        end
        pulse(0);
        tick(2);
        chk(stb, 1'b0);
        wr_reg(IRQ_MASK_ADDR, 16'h0001);
        rd_reg(IRQ_STAT_ADDR, 16'h0004);
        wr_reg(STROBE_CTRL_ADDR, 16'h0700);
        pulse(0);
        tick(2);
        chk(stb, 1'b1);
        chk(irq, 1'b1);
        rd_reg(STROBE_CTRL_ADDR, 16'hC700);
        rd_reg(IRQ_STAT_ADDR, 16'h0005);
        tick(2);
        chk(irq, 1'b0);
        pulse(3);
        tick(2);
        chk(stb, 1'b0);
        chk(irq, 1'b0);
        rd_reg(STROBE_CTRL_ADDR, 16'h4700);
        rd_reg(IRQ_STAT_ADDR, 16'h0002);
        wr_reg(STROBE_CTRL_ADDR, 16'h2601);
        @(posedge clk);
        vbl <= 1'b1;
        tick(2);
        chk(integ, 1'b1);
        pulse(3);
        tick(4);
        chk(stb, 1'b0);
        pulse(1);
        tick(1100);
        chk(width, 18'h00400);
        wr_reg(STROBE_CTRL_ADDR, 16'h2201);
        pulse(1);
        tick(4);
        chk(stb, 1'b0);
        pulse(3);
        tick(2);
        chk(stb, 1'b1);
        tick(1100);
        chk(width, 18'h00400);
        wr_reg(STROBE_CTRL_ADDR, 16'h26FF);
        pulse(1);
        tick(100);
        chk(stb, 1'b1);
        pulse(2);
        tick(2);
        chk(stb, 1'b0);
        wr_reg(STROBE_CTRL_ADDR, 16'h2610);
        pulse(1);
        tick(4);
        chk(stb, 1'b1);
        @(posedge clk);
        vbl <= 1'b0;
        tick(2);
        chk(stb, 1'b0);
        pulse(1);
        tick(4);
        chk(stb, 1'b0);
        @(posedge clk);
        vbl <= 1'b1;
        wr_reg(STROBE_CTRL_ADDR, 16'h3401);
        pulse(1);
        tick(4);
        chk(stb, 1'b0);
        pulse(0);
        pulse(0);
        pulse(1);
        tick(4);
        chk(stb, 1'b1);
        tick(1100);
        pulse(1);
        tick(4);
        chk(stb, 1'b0);
        chk(npulse, 8'h06);
        wr_reg(STROBE_CTRL_ADDR, 16'h0600);
        pulse(0);
        tick(2);
        chk(stb, 1'b0);
        chk(integ, 1'b0);
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(STROBE_CTRL_ADDR, 16'h0700);
        pulse(0);
        @(posedge clk);
        ce <= 1'b1;
        tick(2);
        chk(stb, 1'b0);
        rd_reg(STROBE_CTRL_ADDR, 16'h0600);
        report_and_stop();
    end
endmodule : tb
